// [pkg/irpm_pkg.sv]
// interrupt pin routing maps: register map, field layout, timing constants
// assumes a 250 MHz system clock and a classic wishbone register slave
package irpm_pkg;
    // register indices; byte address on the bus is index * 4
    localparam logic [5:0] IDX_ROUTE_A = 6'h2C;
    localparam logic [5:0] IDX_ROUTE_B = 6'h2D;
    localparam logic [5:0] IDX_CONTROL = 6'h3E;
    localparam logic [5:0] IDX_STATUS = 6'h3F;

    localparam logic [7:0] RST_ROUTE_A = 8'h00;
    localparam logic [7:0] RST_ROUTE_B = 8'h00;
    localparam logic [7:0] SOFT_RESET_CODE = 8'h52;

    // pin a routing fields
    localparam int FUSE_COMPLETE_TO_PIN_A = 7;
    localparam int FUSE_REQUEST_TO_PIN_A = 6;
    localparam int UNDERVOLTAGE_TO_PIN_A = 5;
    localparam int OVERRANGE_TO_PIN_A = 4;
    localparam int PARITY_FAULT_TO_PIN_A = 3;
    localparam int THREE_KNOCK_TO_PIN_A = 2;
    localparam int TWO_KNOCK_TO_PIN_A = 1;
    localparam int ONE_KNOCK_TO_PIN_A = 0;

    // pin b routing fields
    localparam int FUSE_PENDING_TO_PIN_B = 7;
    localparam int STILLNESS_TO_PIN_B = 6;
    localparam int MOTION_TO_PIN_B = 5;
    localparam int ROUTE_B_RESERVED = 4;
    localparam int QUEUE_LEVEL_TO_PIN_B = 3;
    localparam int QUEUE_OVERFLOW_TO_PIN_B = 2;
    localparam int QUEUE_FULL_TO_PIN_B = 1;
    localparam int SAMPLE_READY_TO_PIN_B = 0;

    // status register fields
    localparam int STAT_PIN_A = 0;
    localparam int STAT_PIN_B = 1;

    // bits of pin b map that act when written 1; full is inverted
    localparam logic [7:0] ROUTE_B_USED = 8'hEF;
    localparam logic [7:0] ROUTE_B_INVERT = 8'h02;

    // post soft reset initialisation time
    localparam int CLK_PERIOD_PS = 4000;
    localparam int INIT_TIME_NS = 500000;
    localparam int INIT_CYCLES = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;

    // event levels from on-chip generators, same clock domain
    typedef struct packed {
        logic fuse_complete_status;
        logic fuse_request;
        logic undervoltage_latched;
        logic overrange_latched;
        logic parity_fault;
        logic three_knock;
        logic two_knock;
        logic one_knock;
        logic fuse_pending;
        logic stillness;
        logic motion;
        logic queue_level;
        logic queue_overflow;
        logic queue_full;
        logic sample_ready;
    } irpm_events_type;
endpackage

// [rtl/irpm_route_top.sv]
// interrupt pin routing maps: two enable maps steer events onto two pins
// assumes events arrive on i_clk and a wishbone master drives the bus
//
// Overview of operation
// - pin a map bit 7 passes fuse completion status to pin a.
// - pin a map bit 6 passes fuse request status to pin a.
// - pin a map bit 5 passes latched undervoltage to pin a.
// - pin a map bit 4 passes latched overrange to pin a.
// - pin a map bit 3 passes parity fault to pin a.
// - pin a map bit 2 passes triple tap to pin a.
// - pin a map bit 1 passes double tap to pin a.
// - pin a map bit 0 passes single tap to pin a.
// - pin b map bit 7 passes fuse busy status to pin b.
// - pin b map bit 6 passes inactivity to pin b.
// - pin b map bit 5 passes activity to pin b.
// - pin b map bit 3 passes queue watermark to pin b.
// - pin b map bit 2 passes queue overrun to pin b.
// - pin b map bit 1 inverted: zero passes queue full to pin b.
// - pin b map bit 0 passes sample ready to pin b.
// - pin a map at index 0x2C, resets to zero.
// - pin b map at index 0x2D, resets to zero.
// - pin b map bit 4 reserved, resets zero, has no effect.
// - soft reset floats both pins while registers reinitialise.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module irpm_route_top #(
    parameter int ADR_W = 8,
    parameter int INIT_CYCLES = irpm_pkg::INIT_CYCLES,
    parameter int CNT_W = 17
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire irpm_pkg::irpm_events_type i_events,
    output logic o_irq_pin_a,
    output logic o_irq_pin_a_oe,
    output logic o_irq_pin_b,
    output logic o_irq_pin_b_oe
);
    // refuse sizes the decode, the counter or the float check cannot serve
    if (ADR_W < 8 || ADR_W > 32) begin
        $error("ADR_W must lie in 8..32");
    end
    if (INIT_CYCLES < 8 || INIT_CYCLES >= (1 << CNT_W)) begin
        $error("INIT_CYCLES must fit CNT_W bits and be at least 8");
    end

    function automatic logic idx_hit(input logic [ADR_W-1:0] adr,
                                     input logic [5:0] idx);
        idx_hit = adr[ADR_W-1:2] == (ADR_W-2)'(idx);
    endfunction

    function automatic logic any_enabled(input logic [7:0] src,
                                         input logic [7:0] en);
        any_enabled = |(src & en);
    endfunction

    logic [7:0] route_a_reg;
    logic [7:0] route_a_next;
    logic [7:0] route_b_reg;
    logic [7:0] route_b_next;
    logic busy_reg;
    logic busy_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic pin_a_reg;
    logic pin_a_next;
    logic pin_b_reg;
    logic pin_b_next;
    logic oe_reg;
    logic oe_next;

    // bus decode; answer in the cycle after the request, one-cycle ack
    wire logic req = i_wb_cyc && i_wb_stb && !ack_reg;
    wire logic wr = req && i_wb_we && i_wb_sel[0];
    wire logic hit_a = idx_hit(i_wb_adr, irpm_pkg::IDX_ROUTE_A);
    wire logic hit_b = idx_hit(i_wb_adr, irpm_pkg::IDX_ROUTE_B);
    wire logic hit_ctl = idx_hit(i_wb_adr, irpm_pkg::IDX_CONTROL);
    wire logic hit_st = idx_hit(i_wb_adr, irpm_pkg::IDX_STATUS);
    // only the soft reset code is honoured while initialising
    wire logic soft_rst = wr && hit_ctl &&
        i_wb_dat[7:0] == irpm_pkg::SOFT_RESET_CODE;
    wire logic wr_a = wr && hit_a && !busy_reg;
    wire logic wr_b = wr && hit_b && !busy_reg;

    // source vectors line up with their map bits
    wire logic [7:0] src_a = {
        i_events.fuse_complete_status,
        i_events.fuse_request,
        i_events.undervoltage_latched,
        i_events.overrange_latched,
        i_events.parity_fault,
        i_events.three_knock,
        i_events.two_knock,
        i_events.one_knock
    };
    wire logic [7:0] src_b = {
        i_events.fuse_pending,
        i_events.stillness,
        i_events.motion,
        1'b0,
        i_events.queue_level,
        i_events.queue_overflow,
        i_events.queue_full,
        i_events.sample_ready
    };
    wire logic [7:0] en_b =
        (route_b_reg ^ irpm_pkg::ROUTE_B_INVERT) & irpm_pkg::ROUTE_B_USED;
    wire logic any_a = any_enabled(src_a, route_a_reg);
    wire logic any_b = any_enabled(src_b, en_b);

    wire logic [31:0] rdata =
        busy_reg ? 32'h0000_0000 :
        hit_a ? {24'h00_0000, route_a_reg} :
        hit_b ? {24'h00_0000, route_b_reg} :
        hit_st ? {30'h0000_0000, pin_b_reg, pin_a_reg} :
        32'h0000_0000;

    assign ack_next = req;
    assign dat_next = (req && !i_wb_we) ? rdata : 32'h0000_0000;
    // soft reset clears maps, starts init
    assign route_a_next = soft_rst ? irpm_pkg::RST_ROUTE_A :
        wr_a ? i_wb_dat[7:0] : route_a_reg;
    assign route_b_next = soft_rst ? irpm_pkg::RST_ROUTE_B :
        wr_b ? i_wb_dat[7:0] : route_b_reg;
    assign busy_next = soft_rst || (busy_reg && cnt_reg != '0);
    assign cnt_next = soft_rst ? CNT_W'(INIT_CYCLES - 1) :
        (busy_reg && cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    // pins float, driven low, while busy
    assign oe_next = !busy_next;
    assign pin_a_next = any_a && !busy_next;
    assign pin_b_next = any_b && !busy_next;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            route_a_reg <= irpm_pkg::RST_ROUTE_A;
            route_b_reg <= irpm_pkg::RST_ROUTE_B;
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            route_a_reg <= route_a_next;
            route_b_reg <= route_b_next;
            busy_reg <= busy_next;
            cnt_reg <= cnt_next;
        end
    end

    // cold reset drives the pins low; only soft reset floats them
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            pin_a_reg <= 1'b0;
            pin_b_reg <= 1'b0;
            oe_reg <= 1'b1;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            pin_a_reg <= pin_a_next;
            pin_b_reg <= pin_b_next;
            oe_reg <= oe_next;
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = dat_reg;
    assign o_irq_pin_a = pin_a_reg;
    assign o_irq_pin_b = pin_b_reg;
    assign o_irq_pin_a_oe = oe_reg;
    assign o_irq_pin_b_oe = oe_reg;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    wire logic live = !busy_reg && !soft_rst;

    // cycles spent initialising; lets one check span the whole count
    // without a long repetition
    logic [CNT_W:0] init_seen_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst || soft_rst) begin
            init_seen_reg <= '0;
        end else if (busy_reg) begin
            init_seen_reg <= init_seen_reg + 1'b1;
        end
    end

    // reference pins from the field positions, not from src_a or src_b,
    // so a swapped source order in the datapath cannot hide from checks
    wire logic [7:0] ref_hit_a = {
        route_a_reg[irpm_pkg::FUSE_COMPLETE_TO_PIN_A] &
            i_events.fuse_complete_status,
        route_a_reg[irpm_pkg::FUSE_REQUEST_TO_PIN_A] &
            i_events.fuse_request,
        route_a_reg[irpm_pkg::UNDERVOLTAGE_TO_PIN_A] &
            i_events.undervoltage_latched,
        route_a_reg[irpm_pkg::OVERRANGE_TO_PIN_A] &
            i_events.overrange_latched,
        route_a_reg[irpm_pkg::PARITY_FAULT_TO_PIN_A] &
            i_events.parity_fault,
        route_a_reg[irpm_pkg::THREE_KNOCK_TO_PIN_A] &
            i_events.three_knock,
        route_a_reg[irpm_pkg::TWO_KNOCK_TO_PIN_A] &
            i_events.two_knock,
        route_a_reg[irpm_pkg::ONE_KNOCK_TO_PIN_A] &
            i_events.one_knock
    };
    wire logic [6:0] ref_hit_b = {
        route_b_reg[irpm_pkg::FUSE_PENDING_TO_PIN_B] &
            i_events.fuse_pending,
        route_b_reg[irpm_pkg::STILLNESS_TO_PIN_B] &
            i_events.stillness,
        route_b_reg[irpm_pkg::MOTION_TO_PIN_B] &
            i_events.motion,
        route_b_reg[irpm_pkg::QUEUE_LEVEL_TO_PIN_B] &
            i_events.queue_level,
        route_b_reg[irpm_pkg::QUEUE_OVERFLOW_TO_PIN_B] &
            i_events.queue_overflow,
        // full enables at zero
        !route_b_reg[irpm_pkg::QUEUE_FULL_TO_PIN_B] &
            i_events.queue_full,
        route_b_reg[irpm_pkg::SAMPLE_READY_TO_PIN_B] &
            i_events.sample_ready
    };
    wire logic ref_a = |ref_hit_a;
    wire logic ref_b = |ref_hit_b;

    fuse_done_a_a: assert property (
        live && route_a_reg[7] && i_events.fuse_complete_status
        |=> o_irq_pin_a && o_irq_pin_a_oe)
        else $error("fuse completion not routed to pin a");
    fuse_req_a_a: assert property (
        live && route_a_reg[6] && i_events.fuse_request |=> o_irq_pin_a)
        else $error("fuse request not routed to pin a");
    uvolt_a_a: assert property (
        live && route_a_reg[5] && i_events.undervoltage_latched
        |=> o_irq_pin_a)
        else $error("undervoltage not routed to pin a");
    ovrange_a_a: assert property (
        live && route_a_reg[4] && i_events.overrange_latched |=> o_irq_pin_a)
        else $error("overrange not routed to pin a");
    parity_a_a: assert property (
        live && route_a_reg[3] && i_events.parity_fault |=> o_irq_pin_a)
        else $error("parity fault not routed to pin a");
    knock3_a_a: assert property (
        live && route_a_reg[2] && i_events.three_knock |=> o_irq_pin_a)
        else $error("triple tap not routed to pin a");
    knock2_a_a: assert property (
        live && route_a_reg[1] && i_events.two_knock |=> o_irq_pin_a)
        else $error("double tap not routed to pin a");
    knock1_a_a: assert property (
        live && route_a_reg[0] && i_events.one_knock |=> o_irq_pin_a)
        else $error("single tap not routed to pin a");
    fuse_busy_b_a: assert property (
        live && route_b_reg[7] && i_events.fuse_pending
        |=> o_irq_pin_b && o_irq_pin_b_oe)
        else $error("fuse busy not routed to pin b");
    still_b_a: assert property (
        live && route_b_reg[6] && i_events.stillness |=> o_irq_pin_b)
        else $error("inactivity not routed to pin b");
    motion_b_a: assert property (
        live && route_b_reg[5] && i_events.motion |=> o_irq_pin_b)
        else $error("activity not routed to pin b");
    qlevel_b_a: assert property (
        live && route_b_reg[3] && i_events.queue_level |=> o_irq_pin_b)
        else $error("watermark not routed to pin b");
    qovf_b_a: assert property (
        live && route_b_reg[2] && i_events.queue_overflow |=> o_irq_pin_b)
        else $error("overrun not routed to pin b");
    qfull_b_a: assert property (
        live && !route_b_reg[1] && i_events.queue_full |=> o_irq_pin_b)
        else $error("queue full not routed at map bit zero");
    sample_b_a: assert property (
        live && route_b_reg[0] && i_events.sample_ready |=> o_irq_pin_b)
        else $error("sample ready not routed to pin b");
    map_a_write_a: assert property (
        wr_a |=> route_a_reg == $past(i_wb_dat[7:0]) ##1 o_wb_ack == 1'b0)
        else $error("pin a map write at 0x2C failed");
    map_b_reset_a: assert property (
        $past(i_rst) |-> route_b_reg == 8'h00 && route_a_reg == 8'h00)
        else $error("routing maps not zero after reset");
    reserved_bit_a: assert property (
        live && route_b_reg == 8'h10 && !i_events.queue_full |=> !o_irq_pin_b)
        else $error("reserved map bit drives pin b");
    pin_idle_a: assert property (
        live && !any_a && !any_b |=> !o_irq_pin_a && !o_irq_pin_b)
        else $error("pin raised with no enabled source");
    soft_float_a: assert property (
        soft_rst |=> (!o_irq_pin_a_oe && !o_irq_pin_b_oe && busy_reg)[*8])
        else $error("pins not floated after soft reset");
    pin_a_exact_a: assert property (
        live |=> o_irq_pin_a == $past(ref_a))
        else $error("pin a differs from its enabled sources");
    pin_b_exact_a: assert property (
        live |=> o_irq_pin_b == $past(ref_b))
        else $error("pin b differs from its enabled sources");
    map_a_quiet_a: assert property (
        live && route_a_reg == irpm_pkg::RST_ROUTE_A |=> !o_irq_pin_a)
        else $error("pin a raised with a cleared map");
    map_b_quiet_a: assert property (
        live && route_b_reg == irpm_pkg::RST_ROUTE_B
        |=> o_irq_pin_b == $past(i_events.queue_full))
        else $error("cleared map b passes more than queue full");
    map_b_write_a: assert property (
        wr_b |=> route_b_reg == $past(i_wb_dat[7:0]))
        else $error("pin b map write at 0x2D failed");
    sel_drop_a: assert property (
        req && i_wb_we && !i_wb_sel[0]
        |=> $stable(route_a_reg) && $stable(route_b_reg))
        else $error("write without byte lane 0 changed a map");
    unmapped_a: assert property (
        wr && !hit_a && !hit_b && !soft_rst
        |=> $stable(route_a_reg) && $stable(route_b_reg))
        else $error("write to an unmapped index changed a map");
    ack_pulse_a: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("acknowledge held past one cycle");
    ack_next_a: assert property (
        req |=> o_wb_ack)
        else $error("request not acknowledged in the next cycle");
    dat_idle_a: assert property (
        !o_wb_ack |-> o_wb_dat == 32'h0000_0000)
        else $error("read data shown outside an acknowledge");
    read_a_back_a: assert property (
        req && !i_wb_we && hit_a && !busy_reg
        |=> o_wb_dat == {24'h00_0000, $past(route_a_reg)})
        else $error("pin a map read back wrong");
    status_read_a: assert property (
        req && !i_wb_we && hit_st && !busy_reg
        |=> o_wb_dat[31:2] == 30'h0000_0000 &&
            o_wb_dat[1:0] == $past({o_irq_pin_b, o_irq_pin_a}))
        else $error("status read does not show the pins");
    ctl_read_a: assert property (
        req && !i_wb_we && hit_ctl |=> o_wb_dat == 32'h0000_0000)
        else $error("control index read back nonzero");
    busy_read_a: assert property (
        req && !i_wb_we && busy_reg |=> o_wb_dat == 32'h0000_0000)
        else $error("read during initialisation returned data");
    busy_hold_a: assert property (
        busy_reg && !soft_rst
        |=> $stable(route_a_reg) && $stable(route_b_reg))
        else $error("map changed during initialisation");
    soft_clear_a: assert property (
        soft_rst |=> route_a_reg == irpm_pkg::RST_ROUTE_A &&
            route_b_reg == irpm_pkg::RST_ROUTE_B)
        else $error("soft reset left a map set");
    float_low_a: assert property (
        !o_irq_pin_a_oe |-> !o_irq_pin_a && !o_irq_pin_b && !o_irq_pin_b_oe)
        else $error("pin driven high while floated");
    init_len_a: assert property (
        $fell(busy_reg) |-> init_seen_reg == (CNT_W+1)'(INIT_CYCLES))
        else $error("initialisation did not last its count");
    init_end_a: assert property (
        $fell(busy_reg) |-> o_irq_pin_a_oe && o_irq_pin_b_oe)
        else $error("pins not driven again after initialisation");
    cold_state_a: assert property (
        $past(i_rst) |-> o_irq_pin_a_oe && !o_irq_pin_a && !o_wb_ack)
        else $error("outputs wrong at reset release");

    soft_reset_c: cover property (soft_rst ##1 busy_reg);
    pin_a_fire_c: cover property (live && any_a ##1 o_irq_pin_a);
    full_default_c: cover property (live && route_b_reg == 8'h00 &&
        i_events.queue_full ##1 o_irq_pin_b);
    read_map_c: cover property (req && !i_wb_we && hit_a ##1 o_wb_ack);
    busy_end_c: cover property ($fell(busy_reg));
endmodule

// [verification/irpm_host_model.sv]
// host side of the two interrupt lines: resolves what the host sees
// assumes push-pull pins with an enable; no pull resistor on either line
`timescale 1ns/1ps
module irpm_host_model (
    input wire logic i_clk,
    input wire logic i_pin_a,
    input wire logic i_pin_a_oe,
    input wire logic i_pin_b,
    input wire logic i_pin_b_oe,
    output logic o_line_a,
    output logic o_line_b
);
    // floating line toggles so a stale level is never mistaken for a drive
    always_ff @(posedge i_clk) begin
        o_line_a <= i_pin_a_oe ? i_pin_a : ~o_line_a;
        o_line_b <= i_pin_b_oe ? i_pin_b : ~o_line_b;
    end
endmodule

// [verification/irpm_route_tb.sv]
// self-checking bench for the interrupt routing maps
// assumes a wishbone slave acking one cycle after a request is taken
`timescale 1ns/1ps
module interrupt_pin_routing_maps_tb_top;
    logic i_clk, i_rst, cyc, stb, we, ack, pa, pa_oe, pb, pb_oe, la, lb;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    irpm_pkg::irpm_events_type ev;
    int bad_count = 0;
    int samples_checked = 0;

    irpm_route_top #(.INIT_CYCLES(20)) DUT (.i_clk(i_clk), .i_rst(i_rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
        .i_events(ev), .o_irq_pin_a(pa), .o_irq_pin_a_oe(pa_oe),
        .o_irq_pin_b(pb), .o_irq_pin_b_oe(pb_oe));
    irpm_host_model host (.i_clk(i_clk), .i_pin_a(pa), .i_pin_a_oe(pa_oe),
        .i_pin_b(pb), .i_pin_b_oe(pb_oe), .o_line_a(la), .o_line_b(lb));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle; request held until ack is sampled at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic s0);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= {3'h0, s0};
        wdat <= {24'h000000, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic settle(input logic [14:0] x);
        ev <= irpm_pkg::irpm_events_type'(x);
        repeat (4) @(posedge i_clk);
    endtask

    task automatic reset_values();
        wb(1'b0, 8'hB0, 8'h00, 1'b1);
        check("map_a reset", q, 32'h0);
        wb(1'b0, 8'hB4, 8'h00, 1'b1);
        check("map_b reset", q, 32'h0);
        settle(15'h0002);
        check("full at reset", {pb_oe, lb}, 32'h3);
        wb(1'b0, 8'hFC, 8'h00, 1'b1);
        check("status", q, 32'h2);
        settle(15'h7FFF);
        check("pin_a at reset", {pa_oe, la}, 32'h2);
    endtask

    task automatic pin_a_walk();
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'hB0, 8'h01 << i, 1'b1);
            wb(1'b0, 8'hB0, 8'h00, 1'b1);
            check("map_a back", q, 32'h1 << i);
            settle(15'h0001 << (7 + i));
            check("pin_a on", la, 32'h1);
            settle(~(15'h0001 << (7 + i)));
            check("pin_a off", la, 32'h0);
        end
    endtask

    task automatic pin_b_walk();
        int mb[6] = '{7, 6, 5, 3, 2, 0};
        int eb[6] = '{6, 5, 4, 3, 2, 0};
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, 8'hB4, (8'h01 << mb[i]) | 8'h02, 1'b1);
            settle(15'h0001 << eb[i]);
            check("pin_b on", lb, 32'h1);
            settle(~(15'h0001 << eb[i]));
            check("pin_b off", lb, 32'h0);
        end
        wb(1'b1, 8'hB4, 8'h02, 1'b1);
        settle(15'h0002);
        check("full masked", lb, 32'h0);
        wb(1'b1, 8'hB4, 8'h10, 1'b1);
        wb(1'b0, 8'hB4, 8'h00, 1'b1);
        check("reserved back", q, 32'h10);
        settle(15'h7FFD);
        check("reserved quiet", lb, 32'h0);
    endtask

    task automatic bus_refusals();
        wb(1'b1, 8'hB0, 8'hA5, 1'b1);
        wb(1'b1, 8'hB0, 8'h5A, 1'b0);
        wb(1'b0, 8'hB0, 8'h00, 1'b1);
        check("sel0 dropped", q, 32'hA5);
        wb(1'b1, 8'h40, 8'hFF, 1'b1);
        wb(1'b0, 8'h40, 8'h00, 1'b1);
        check("unmapped", q, 32'h0);
        wb(1'b0, 8'hF8, 8'h00, 1'b1);
        check("control reads 0", q, 32'h0);
    endtask

    task automatic soft_reset();
        wb(1'b1, 8'hB0, 8'hFF, 1'b1);
        wb(1'b1, 8'hF8, 8'h52, 1'b1);
        check("float", {pa_oe, pb_oe}, 32'h0);
        wb(1'b1, 8'hB0, 8'hFF, 1'b1);
        wb(1'b0, 8'hB0, 8'h00, 1'b1);
        check("busy read", q, 32'h0);
        repeat (30) @(posedge i_clk);
        check("driven again", {pa_oe, pb_oe}, 32'h3);
        wb(1'b0, 8'hB0, 8'h00, 1'b1);
        check("map_a cleared", q, 32'h0);
        settle(15'h7FFF);
        check("pins after", {la, lb}, 32'h1);
    endtask

    initial begin
        i_rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        ev = irpm_pkg::irpm_events_type'(15'h0000);
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        reset_values();
        pin_a_walk();
        pin_b_walk();
        bus_refusals();
        soft_reset();
        report_and_stop();
    end
endmodule
